// >>> hdl/pled_top.sv
// pixel strip controller: pixel/frame buffers, register port, four serial outputs
`timescale 1ns/10ps
`include "pled_regs.svh"

module pled_top import pled_pkg::*; #(
	parameter int unsigned CYCLIC_CYC = `PLED_CYCLIC_MS * `PLED_CLK_MHZ * 1000,
	parameter int unsigned RESET_CYC = `PLED_RESET_US * `PLED_CLK_MHZ
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [13:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	input wire logic [3:0] fb_state_i,
	input wire logic field_pwr_ok_i,
	input wire logic bus_fail_i,
	input wire logic pd_valid_i,
	output logic pd_ready_o,
	input wire pled_pd_t pd_i,
	output pled_strip_t [3:0] strip_o
);

	// ----------------------------------------
	// reset release
	// ----------------------------------------
	logic [1:0] rst_sync_r;
	logic rst_n;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) rst_sync_r <= 2'b00;
		else rst_sync_r <= {rst_sync_r[0], 1'b1};
	end
	assign rst_n = rst_sync_r[1];

	function automatic logic [10:0] ch_base(input logic [1:0] c, input logic [2:0] n);
		ch_base = n == 3'h1 ? 11'h000 : n == 3'h2 ? {c[0], 10'h000} : {c, 9'h000};
	endfunction

	localparam pled_chcfg_t CHCFG_RST = '{cfg: `PLED_CFG_RST, npix: `PLED_NPIX_RST, bri: `PLED_BRI_RST,
		default: '0};

	// ----------------------------------------
	// shared state
	// ----------------------------------------
	pled_chcfg_t chc_r [4];
	logic [2:0] nch_r;
	logic err_r, rej_r, dflt_done_r;
	logic [3:0] fill_pend_r, upd_pend_r, ch_fill_go, ch_copy_go, ch_busy;
	logic [3:0] bk_idle, bk_fill, bk_copy;
	logic [1:0] bk_own [4];
	logic [31:0] bk_rd [4];
	logic [10:0] tx_addr [4];
	logic [31:0] fillcol_r [4];
	logic seg_busy_r;
	logic [2:0] seg_k_r;
	logic [10:0] seg_abs_r;
	logic [7:0][31:0] seg_dat_r;

	// ----------------------------------------
	// register decode
	// ----------------------------------------
	wire ch_sel = addr_i[13:7] == `PLED_CH_BASE;
	wire g_sel = addr_i[13:7] == `PLED_G_BASE && addr_i[6:5] == 2'h0;
	wire gam_sel = addr_i[13:12] == `PLED_GAM_BASE;
	wire [2:0] ridx = addr_i[4:2];
	wire [1:0] rch = addr_i[6:5];
	wire ctrl_wr = wr_i && g_sel && ridx == `PLED_G_CTRL && wdata_i[0];
	wire stat_w1c = wr_i && g_sel && ridx == `PLED_G_STAT;
	wire run_ok = fb_state_i == `PLED_ST_OP && field_pwr_ok_i;
	wire dflt_go = ctrl_wr && fb_state_i == `PLED_ST_PREOPERATIONAL_STATE;
	wire dflt_rej = ctrl_wr && fb_state_i != `PLED_ST_PREOPERATIONAL_STATE;
	wire [11:0] lim = nch_r == 3'h1 ? 12'h800 : nch_r == 3'h2 ? 12'h400 : 12'h200;

	// ----------------------------------------
	// process data command port
	// ----------------------------------------
	wire pd_fire = pd_valid_i && pd_ready_o;
	wire pix_op = pd_i.op == PD_WRITE || pd_i.op == PD_SEG;
	wire [11:0] pd_last = {1'b0, pd_i.idx} + (pd_i.op == PD_SEG ? 12'h007 : 12'h000);
	wire [11:0] pd_lim = chc_r[pd_i.ch].npix < lim ? chc_r[pd_i.ch].npix : lim;
	wire pd_bad = {1'b0, pd_i.ch} >= nch_r || (pix_op && pd_last >= pd_lim);
	wire pd_ok = pd_fire && !pd_bad;
	wire [10:0] pd_abs = ch_base(pd_i.ch, nch_r) + pd_i.idx;
	assign pd_ready_o = !seg_busy_r && fill_pend_r == 4'h0 && bk_fill == 4'h0;

	wire [10:0] pw_addr = seg_busy_r ? seg_abs_r + {8'h00, seg_k_r} : pd_abs;
	wire [31:0] pw_data = seg_busy_r ? seg_dat_r[seg_k_r] : pd_i.col;
	wire pw_en = seg_busy_r || (pd_ok && pd_i.op == PD_WRITE);

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			seg_busy_r <= 1'b0;
			seg_k_r <= 3'h0;
		end else if (seg_busy_r) begin
			seg_k_r <= seg_k_r + 3'h1;
			seg_busy_r <= seg_k_r != 3'h7;
		end else if (pd_ok && pd_i.op == PD_SEG) begin
			seg_busy_r <= 1'b1;
			seg_k_r <= 3'h0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (pd_ok && pd_i.op == PD_SEG && !seg_busy_r) begin
			seg_abs_r <= pd_abs;
			seg_dat_r <= pd_i.seg;
		end
	end

	// ----------------------------------------
	// global registers
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			nch_r <= `PLED_NCH_RST;
			err_r <= 1'b0;
			rej_r <= 1'b0;
			dflt_done_r <= 1'b0;
		end else begin
			if (dflt_go) nch_r <= `PLED_NCH_RST;
			else if (wr_i && g_sel && ridx == `PLED_G_CFG) nch_r <= wdata_i[2:0];
			err_r <= (pd_fire && pd_bad) || (err_r && !(stat_w1c && wdata_i[0]));
			rej_r <= dflt_rej || (rej_r && !(stat_w1c && wdata_i[1]));
			dflt_done_r <= dflt_go || (dflt_done_r && !(stat_w1c && wdata_i[2]));
		end
	end

	// ----------------------------------------
	// register read, data in the next cycle
	// ----------------------------------------
	pled_chcfg_t rc;
	logic [31:0] rd_val;
	assign rc = chc_r[rch];
	always_comb begin
		rd_val = 32'h0000_0000;
		if (ch_sel) begin
			case (ridx)
				`PLED_R_CFG: rd_val = {22'h000000, rc.cfg};
				`PLED_R_NPIX: rd_val = {20'h00000, rc.npix};
				`PLED_R_BRI: rd_val = {23'h000000, rc.bri};
				`PLED_R_WDCOL: rd_val = rc.wdcol;
				`PLED_R_CUST: rd_val = {1'b0, rc.cust};
				`PLED_R_CRST: rd_val = {16'h0000, rc.crst};
				`PLED_R_CUR: rd_val = rc.cur;
				default: rd_val = {30'h00000000, upd_pend_r[rch], ch_busy[rch]};
			endcase
		end else if (g_sel && ridx == `PLED_G_CFG) begin
			rd_val = {29'h00000000, nch_r};
		end else if (g_sel && ridx == `PLED_G_STAT) begin
			rd_val = {29'h00000000, dflt_done_r, rej_r, err_r};
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) rdata_o <= 32'h0000_0000;
		else rdata_o <= rd_i ? rd_val : 32'h0000_0000;
	end

	// ----------------------------------------
	// buffer banks, 512 words each
	// ----------------------------------------
	for (genvar b = 0; b < 4; b++) begin : g_bank
		logic [31:0] pix_mem [512];
		logic [31:0] frm_mem [512];
		pled_bank_t op_r;
		logic [8:0] cnt_r;
		assign bk_own[b] = nch_r == 3'h1 ? 2'h0 : nch_r == 3'h2 ? 2'(b / 2) : 2'(b);
		assign bk_idle[b] = op_r == BK_IDLE;
		assign bk_fill[b] = op_r == BK_FILL;
		assign bk_copy[b] = op_r == BK_COPY;
		assign bk_rd[b] = frm_mem[tx_addr[bk_own[b]][8:0]];

		always_ff @(posedge clk_i or negedge rst_n) begin
			if (!rst_n) begin
				op_r <= BK_IDLE;
				cnt_r <= 9'h000;
			end else begin
				case (op_r)
					BK_IDLE: begin
						cnt_r <= 9'h000;
						if (ch_fill_go[bk_own[b]]) op_r <= BK_FILL;
						else if (ch_copy_go[bk_own[b]]) op_r <= BK_COPY;
					end
					BK_FILL, BK_COPY: begin
						cnt_r <= cnt_r + 9'h001;
						if (cnt_r == 9'h1ff) op_r <= BK_IDLE;
					end
					default: op_r <= BK_IDLE;
				endcase
			end
		end

		always_ff @(posedge clk_i) begin
			if (op_r == BK_FILL) pix_mem[cnt_r] <= fillcol_r[bk_own[b]];
			else if (pw_en && pw_addr[10:9] == 2'(b)) pix_mem[pw_addr[8:0]] <= pw_data;
			if (op_r == BK_COPY) frm_mem[cnt_r] <= pix_mem[cnt_r];
		end
	end

	// ----------------------------------------
	// per-channel configuration and output
	// ----------------------------------------
	for (genvar c = 0; c < 4; c++) begin : g_ch
		pled_chcfg_t cc;
		logic [7:0] gam_mem [256];
		pled_tx_t st_r;
		logic [11:0] pix_r;
		logic cur_ph_r, wd_r, req_r, wd_prev_r;
		logic [31:0] sh_r;
		logic [5:0] nb_r;
		logic [19:0] tcnt_r;
		logic [24:0] cyc_r;
		logic [9:0] per, t0, t1;
		logic [19:0] gap;
		logic inv, syn, need_cur;
		logic [3:0] mine;
		logic [7:0] cv [4];
		logic [23:0] ord;

		assign cc = chc_r[c];
		wire wr_me = wr_i && ch_sel && rch == 2'(c);
		wire cmd_me = pd_ok && pd_i.ch == 2'(c);

		always_ff @(posedge clk_i or negedge rst_n) begin
			if (!rst_n) chc_r[c] <= CHCFG_RST;
			else if (dflt_go) chc_r[c] <= CHCFG_RST;
			else if (wr_me) begin
				case (ridx)
					`PLED_R_CFG: chc_r[c].cfg <= wdata_i[9:0];
					`PLED_R_NPIX: chc_r[c].npix <= wdata_i[11:0];
					`PLED_R_BRI: chc_r[c].bri <= wdata_i[8:0];
					`PLED_R_WDCOL: chc_r[c].wdcol <= wdata_i;
					`PLED_R_CUST: chc_r[c].cust <= wdata_i[30:0];
					`PLED_R_CRST: chc_r[c].crst <= wdata_i[15:0];
					`PLED_R_CUR: chc_r[c].cur <= wdata_i;
					default: chc_r[c].cfg <= cc.cfg;
				endcase
			end
		end

		always_ff @(posedge clk_i) begin
			if (wr_i && gam_sel && addr_i[11:10] == 2'(c)) gam_mem[addr_i[9:2]] <= wdata_i[7:0];
			if (cmd_me && pd_i.op == PD_FILL) fillcol_r[c] <= pd_i.col;
		end

		// banks owned, fill/update hand-off
		for (genvar b = 0; b < 4; b++) begin : g_own
			assign mine[b] = bk_own[b] == 2'(c);
		end
		wire banks_idle = &(bk_idle | ~mine);
		wire copying = |(bk_copy & mine);
		assign ch_fill_go[c] = fill_pend_r[c] && banks_idle;
		assign ch_copy_go[c] = upd_pend_r[c] && banks_idle && !fill_pend_r[c] && st_r == TX_IDLE;
		assign ch_busy[c] = st_r != TX_IDLE;

		wire wd_act = bus_fail_i && cc.cfg[`PLED_CFG_WDCOL];
		wire hold = bus_fail_i && !cc.cfg[`PLED_CFG_WDCOL];
		wire start = st_r == TX_IDLE && run_ok && req_r && !hold && !copying && !upd_pend_r[c];
		wire cyc_tick = cyc_r == 25'(CYCLIC_CYC - 1);
		wire [11:0] n_eff = cc.npix < lim ? cc.npix : lim;

		always_ff @(posedge clk_i or negedge rst_n) begin
			if (!rst_n) begin
				fill_pend_r[c] <= 1'b0;
				upd_pend_r[c] <= 1'b0;
				req_r <= 1'b0;
				wd_prev_r <= 1'b0;
				cyc_r <= 25'h0000000;
			end else begin
				fill_pend_r[c] <= (cmd_me && pd_i.op == PD_FILL) || (fill_pend_r[c] && !ch_fill_go[c]);
				upd_pend_r[c] <= (cmd_me && pd_i.op == PD_UPDATE && pd_i.exec) || (upd_pend_r[c] && !ch_copy_go[c]);
				req_r <= (cmd_me && pd_i.op == PD_SEND && pd_i.exec) || cyc_tick || (wd_act && !wd_prev_r) ||
					(req_r && !start);
				wd_prev_r <= wd_act;
				if (!run_ok || !cc.cfg[`PLED_CFG_CYCLIC] || cyc_tick) cyc_r <= 25'h0000000;
				else cyc_r <= cyc_r + 25'h0000001;
			end
		end

		// bit timing by chip type, custom override
		always_comb begin
			per = 10'(`PLED_CYC_LO(`PLED_FAST_BIT_NS));
			t0 = 10'(`PLED_CYC_HI(`PLED_FAST_T0_NS));
			t1 = 10'(`PLED_CYC_HI(`PLED_FAST_T1_NS));
			syn = 1'b0;
			need_cur = 1'b0;
			case (pled_chip_t'(cc.cfg[`PLED_CFG_CHIP]))
				CHIP_SLOW: begin
					per = 10'(`PLED_CYC_LO(`PLED_SLOW_BIT_NS));
					t0 = 10'(`PLED_CYC_HI(`PLED_SLOW_T0_NS));
					t1 = 10'(`PLED_CYC_HI(`PLED_SLOW_T1_NS));
				end
				CHIP_CUR: need_cur = 1'b1;
				CHIP_SYNC: begin
					per = 10'(`PLED_CYC_LO(`PLED_SYNC_BIT_NS));
					syn = 1'b1;
				end
				default: syn = 1'b0;
			endcase
			inv = 1'b0;
			gap = 20'(RESET_CYC);
			if (cc.cfg[`PLED_CFG_CUSTOM]) begin
				per = cc.cust[9:0];
				t0 = cc.cust[19:10];
				t1 = cc.cust[29:20];
				inv = cc.cust[30];
				gap = {4'h0, cc.crst};
			end
		end

		// colour path: gamma, brightness, order
		assign tx_addr[c] = ch_base(2'(c), nch_r) + pix_r[10:0];
		wire [31:0] src = wd_r ? cc.wdcol : bk_rd[tx_addr[c][10:9]];
		for (genvar k = 0; k < 4; k++) begin : g_col
			wire [7:0] raw = src[8*k +: 8];
			wire [7:0] gv = cc.cfg[`PLED_CFG_GAMMA] ? gam_mem[raw] : raw;
			wire [16:0] pr = gv * cc.bri;
			assign cv[k] = pr[16] ? 8'hff : pr[15:8];
		end
		always_comb begin
			case (cc.cfg[`PLED_CFG_ORDER])
				2'h0: ord = {cv[1], cv[2], cv[0]};
				2'h1: ord = {cv[2], cv[1], cv[0]};
				2'h2: ord = {cv[0], cv[2], cv[1]};
				default: ord = {cv[0], cv[1], cv[2]};
			endcase
		end

		// frame sequencer
		wire bit_end = tcnt_r == {10'h000, per} - 20'h00001;
		always_ff @(posedge clk_i or negedge rst_n) begin
			if (!rst_n) begin
				st_r <= TX_IDLE;
				pix_r <= 12'h000;
				cur_ph_r <= 1'b0;
				wd_r <= 1'b0;
				sh_r <= 32'h0000_0000;
				nb_r <= 6'h00;
				tcnt_r <= 20'h00000;
			end else if (!run_ok) begin
				st_r <= TX_IDLE;
			end else begin
				case (st_r)
					TX_IDLE: if (start) begin
						st_r <= TX_LOAD;
						pix_r <= 12'h000;
						cur_ph_r <= need_cur;
						wd_r <= wd_act;
					end
					TX_LOAD: begin
						tcnt_r <= 20'h00000;
						if (cur_ph_r) begin
							sh_r <= cc.cur;
							nb_r <= 6'h20;
							cur_ph_r <= 1'b0;
							st_r <= TX_BIT;
						end else if (pix_r >= n_eff) begin
							st_r <= TX_GAP;
						end else begin
							sh_r <= cc.cfg[`PLED_CFG_FOUR] ? {ord, cv[3]} : {ord, 8'h00};
							nb_r <= cc.cfg[`PLED_CFG_FOUR] ? 6'h20 : 6'h18;
							pix_r <= pix_r + 12'h001;
							st_r <= TX_BIT;
						end
					end
					TX_BIT: if (bit_end) begin
						tcnt_r <= 20'h00000;
						sh_r <= {sh_r[30:0], 1'b0};
						nb_r <= nb_r - 6'h01;
						if (nb_r == 6'h01) st_r <= TX_LOAD;
					end else begin
						tcnt_r <= tcnt_r + 20'h00001;
					end
					TX_GAP: if (tcnt_r == gap - 20'h00001) st_r <= TX_IDLE;
					else tcnt_r <= tcnt_r + 20'h00001;
					default: st_r <= TX_IDLE;
				endcase
			end
		end

		// line drivers
		wire hi = tcnt_r < {10'h000, sh_r[31] ? t1 : t0};
		wire dat_nxt = st_r == TX_BIT ? (syn ? sh_r[31] : hi) ^ inv : inv;
		wire clk_nxt = st_r == TX_BIT && syn && tcnt_r >= {11'h000, per[9:1]};
		always_ff @(posedge clk_i or negedge rst_n) begin
			if (!rst_n) strip_o[c] <= '0;
			else strip_o[c] <= '{dat: dat_nxt, clk: clk_nxt};
		end
	end

endmodule // pled_top

// >>> hdl/pled_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef PLED_REGS_SVH
`define PLED_REGS_SVH
// -------------------------------------------------------------
// address map (byte address, 14 bits)
// -------------------------------------------------------------
`define PLED_CH_BASE 7'h00
`define PLED_G_BASE 7'h01
`define PLED_GAM_BASE 2'h1
`define PLED_R_CFG 3'h0
`define PLED_R_NPIX 3'h1
`define PLED_R_BRI 3'h2
`define PLED_R_WDCOL 3'h3
`define PLED_R_CUST 3'h4
`define PLED_R_CRST 3'h5
`define PLED_R_CUR 3'h6
`define PLED_R_CST 3'h7
`define PLED_G_CFG 3'h0
`define PLED_G_STAT 3'h1
`define PLED_G_CTRL 3'h2
// -------------------------------------------------------------
// fields and reset values
// -------------------------------------------------------------
`define PLED_CFG_CUSTOM 0
`define PLED_CFG_CYCLIC 1
`define PLED_CFG_WDCOL 2
`define PLED_CFG_CHIP 5:3
`define PLED_CFG_ORDER 7:6
`define PLED_CFG_FOUR 8
`define PLED_CFG_GAMMA 9
`define PLED_CFG_RST 10'h002
`define PLED_NPIX_RST 12'h200
`define PLED_BRI_RST 9'h100
`define PLED_NCH_RST 3'h4
`define PLED_ST_PREOPERATIONAL_STATE 4'h2
`define PLED_ST_OP 4'h8
// -------------------------------------------------------------
// timing
// -------------------------------------------------------------
`define PLED_CLK_MHZ 125
`define PLED_CYC_LO(ns) ((ns) * `PLED_CLK_MHZ / 1000)
`define PLED_CYC_HI(ns) (((ns) * `PLED_CLK_MHZ + 999) / 1000)
`define PLED_FAST_BIT_NS 1250
`define PLED_FAST_T0_NS 400
`define PLED_FAST_T1_NS 800
`define PLED_SLOW_BIT_NS 2500
`define PLED_SLOW_T0_NS 800
`define PLED_SLOW_T1_NS 1600
`define PLED_SYNC_BIT_NS 1000
`define PLED_CYCLIC_MS 250
`define PLED_RESET_US 300
`endif

// >>> hdl/pled_pkg.sv
// types shared by the pixel strip controller
package pled_pkg;
	typedef enum logic [2:0] {PD_WRITE = 3'b000, PD_FILL = 3'b001, PD_SEG = 3'b010, PD_UPDATE = 3'b011,
		PD_SEND = 3'b100} pled_op_t;
	typedef enum logic [2:0] {CHIP_FAST = 3'b000, CHIP_SLOW = 3'b001, CHIP_CUR = 3'b010,
		CHIP_SYNC = 3'b011} pled_chip_t;
	typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_LOAD = 2'b01, TX_BIT = 2'b10, TX_GAP = 2'b11} pled_tx_t;
	typedef enum logic [1:0] {BK_IDLE = 2'b00, BK_FILL = 2'b01, BK_COPY = 2'b10} pled_bank_t;
	typedef struct packed {
		pled_op_t op;
		logic exec;
		logic [1:0] ch;
		logic [10:0] idx;
		logic [31:0] col;
		logic [7:0][31:0] seg;
	} pled_pd_t;
	typedef struct packed {
		logic [9:0] cfg;
		logic [11:0] npix;
		logic [8:0] bri;
		logic [31:0] wdcol;
		logic [30:0] cust;
		logic [15:0] crst;
		logic [31:0] cur;
	} pled_chcfg_t;
	typedef struct packed {
		logic dat;
		logic clk;
	} pled_strip_t;
endpackage

// >>> verif/pled_strip_mon.sv
// strip receiver model: turns one-wire pulses into bits
`timescale 1ns/10ps
module pled_strip_mon import pled_pkg::*; #(
	parameter int unsigned HI_MIN = 75
) (
	input wire logic clk_i,
	input wire pled_strip_t strip_i,
	input wire logic clr_i,
	output logic [63:0] bits_o,
	output logic [15:0] cnt_o
);
	logic [15:0] hi_r;
	logic dat_r;
	wire fall = dat_r && !strip_i.dat;
	always_ff @(posedge clk_i) begin
		dat_r <= strip_i.dat;
		hi_r <= strip_i.dat ? hi_r + 16'h1 : 16'h0;
		if (clr_i) begin
			cnt_o <= 16'h0;
			bits_o <= 64'h0;
		end else if (fall) begin
			bits_o <= {bits_o[62:0], hi_r > HI_MIN};
			cnt_o <= cnt_o + 16'h1;
		end
	end
endmodule // pled_strip_mon

// >>> verif/pled_top_chk.sv
// port assertions for the pixel strip controller
`timescale 1ns/10ps
module pled_top_chk import pled_pkg::*; #(
	parameter int unsigned CYCLIC_CYC = 1,
	parameter int unsigned RESET_CYC = 1
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [13:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [31:0] rdata_o,
	input wire logic [3:0] fb_state_i,
	input wire logic field_pwr_ok_i,
	input wire logic bus_fail_i,
	input wire logic pd_valid_i,
	input wire logic pd_ready_o,
	input wire pled_pd_t pd_i,
	input wire pled_strip_t [3:0] strip_o
);
	wire tx_ok = (fb_state_i == 4'h8) && field_pwr_ok_i;
	wire take = pd_valid_i && pd_ready_o;
	wire busy_op = pd_valid_i && (pd_i.op == PD_SEG || pd_i.op == PD_FILL);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	property p_hold;
		!tx_ok [*4] |-> $stable(strip_o);
	endproperty
	a_hold: assert property (p_hold) else $error("strip moved outside operational state");
	property p_rd_idle;
		!$past(rd_i) |-> rdata_o == 32'h0;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
	property p_unmap;
		rd_i && addr_i >= 14'h008c |=> rdata_o == 32'h0;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped or gamma read not zero");
	property p_npix;
		rd_i && addr_i < 14'h0080 && addr_i[4:0] == 5'h04 |=> rdata_o[31:12] == 20'h0;
	endproperty
	a_npix: assert property (p_npix) else $error("pixel count upper bits set");
	property p_cst;
		rd_i && addr_i < 14'h0080 && addr_i[4:0] == 5'h1c |=> rdata_o[31:2] == 30'h0;
	endproperty
	a_cst: assert property (p_cst) else $error("channel status upper bits set");
	property p_seg;
		take && pd_i.op == PD_SEG && pd_i.ch == 2'h2 && pd_i.idx < 11'h008 |=> (!pd_ready_o) [*8];
	endproperty
	a_seg: assert property (p_seg) else $error("segment not held for eight cycles");
	property p_fill;
		take && pd_i.op == PD_FILL && pd_i.ch == 2'h0 |=> (!pd_ready_o) [*8];
	endproperty
	a_fill: assert property (p_fill) else $error("fill released ready early");
	property p_ready;
		$fell(pd_ready_o) |-> $past(busy_op);
	endproperty
	a_ready: assert property (p_ready) else $error("ready dropped without segment or fill");
endmodule // pled_top_chk
bind pled_top pled_top_chk #(.CYCLIC_CYC(CYCLIC_CYC), .RESET_CYC(RESET_CYC)) u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .fb_state_i(fb_state_i),
	.field_pwr_ok_i(field_pwr_ok_i), .bus_fail_i(bus_fail_i), .pd_valid_i(pd_valid_i), .pd_ready_o(pd_ready_o),
	.pd_i(pd_i), .strip_o(strip_o));

// >>> verif/tb_pled_top.sv
// self-checking bench for the pixel strip controller
`timescale 1ns/10ps
module tb_pled_top import pled_pkg::*;;
	typedef struct packed {logic [13:0] a; logic [31:0] d; logic [31:0] e;} pled_row_t;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [13:0] addr_i = 14'h0;
	logic [31:0] wdata_i = 32'h0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [31:0] rdata_o;
	logic [3:0] fb_state_i = 4'h2;
	logic field_pwr_ok_i = 1'b1;
	logic bus_fail_i = 1'b0;
	logic pd_valid_i = 1'b0;
	logic pd_ready_o;
	pled_pd_t pd_i = '0;
	pled_strip_t [3:0] strip_o;
	logic clr = 1'b1;
	logic [63:0] bits;
	logic [15:0] cnt;
	logic [15:0] c0;
	int fails = 0;
	int comparisons = 0;
	pled_row_t rows [12] = '{'{14'h0020, 32'hffffffff, 32'h000003ff}, '{14'h0024, 32'hffffffff, 32'h00000fff},
		'{14'h0028, 32'hffffffff, 32'h000001ff}, '{14'h002c, 32'h12345678, 32'h12345678},
		'{14'h0030, 32'hbfffffff, 32'h3fffffff}, '{14'h0034, 32'hffffffff, 32'h0000ffff},
		'{14'h0038, 32'ha5a5a5a5, 32'ha5a5a5a5}, '{14'h003c, 32'hffffffff, 32'h0},
		'{14'h0090, 32'hffffffff, 32'h0}, '{14'h1400, 32'hffffffff, 32'h0},
		'{14'h0080, 32'h2, 32'h2}, '{14'h0080, 32'h4, 32'h4}};
	always #4 clk_i = ~clk_i;
	pled_top #(.CYCLIC_CYC(8000), .RESET_CYC(20)) DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .fb_state_i(fb_state_i),
		.field_pwr_ok_i(field_pwr_ok_i), .bus_fail_i(bus_fail_i), .pd_valid_i(pd_valid_i), .pd_ready_o(pd_ready_o),
		.pd_i(pd_i), .strip_o(strip_o));
	pled_strip_mon u_mon (.clk_i(clk_i), .strip_i(strip_o[0]), .clr_i(clr), .bits_o(bits), .cnt_o(cnt));
	task automatic stop_test();
		if (fails == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [13:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [13:0] a, output logic [31:0] v);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 v = rdata_o;
	endtask
	task automatic rdc(input string n, input logic [13:0] a, input logic [31:0] e);
		logic [31:0] v;
		rd(a, v);
		chk(n, e, v);
	endtask
	task automatic pd(input pled_op_t op, input logic [1:0] ch, input logic [10:0] idx, input logic [31:0] col);
		@(posedge clk_i);
		pd_i <= {op, 1'b1, ch, idx, col, {8{col}}};
		pd_valid_i <= 1'b1;
		do @(negedge clk_i); while (pd_ready_o !== 1'b1);
		@(posedge clk_i);
		pd_valid_i <= 1'b0;
	endtask
	task automatic clr_mon();
		@(posedge clk_i);
		clr <= 1'b1;
		@(posedge clk_i);
		clr <= 1'b0;
	endtask
	task automatic tx();
		clr_mon();
		pd(PD_SEND, 2'h0, 11'h0, 32'h0);
	endtask
	task automatic idle();
		logic [31:0] v;
		repeat (600) @(posedge clk_i);
		do rd(14'h001c, v); while (v[1:0] !== 2'b00);
	endtask
	task automatic ck(input logic [23:0] e);
		idle();
		chk("frame", {8'h0, e}, {8'h0, bits[23:0]});
		chk("bits", 32'd24, {16'h0, cnt});
	endtask
	initial begin
		#700000;
		fails++;
		stop_test();
	end
	initial begin
		repeat (16) @(posedge clk_i);
		rst_n_i <= 1'b1;
		clr <= 1'b0;
		repeat (3) @(posedge clk_i);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			rdc("reg", rows[i].a, rows[i].e);
		end
		@(posedge clk_i);
		rst_n_i <= 1'b0;
		repeat (16) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rdc("cfg", 14'h0020, 32'h2);
		rdc("npix", 14'h0024, 32'h200);
		rdc("bri", 14'h0028, 32'h100);
		rdc("nch", 14'h0080, 32'h4);
		wr(14'h0028, 32'h55);
		wr(14'h0088, 32'h1);
		rdc("bri", 14'h0028, 32'h100);
		rdc("stat", 14'h0084, 32'h4);
		wr(14'h0084, 32'h4);
		fb_state_i <= 4'h8;
		wr(14'h0088, 32'h1);
		rdc("stat", 14'h0084, 32'h2);
		wr(14'h0084, 32'h2);
		wr(14'h0064, 32'h10);
		pd(PD_WRITE, 2'h3, 11'h00f, 32'h0);
		rdc("stat", 14'h0084, 32'h0);
		pd(PD_WRITE, 2'h3, 11'h010, 32'h0);
		rdc("stat", 14'h0084, 32'h1);
		wr(14'h0084, 32'h1);
		pd(PD_SEG, 2'h3, 11'h008, 32'h0);
		rdc("stat", 14'h0084, 32'h0);
		pd(PD_SEG, 2'h3, 11'h009, 32'h0);
		rdc("stat", 14'h0084, 32'h1);
		wr(14'h0084, 32'h1);
		pd(PD_SEG, 2'h2, 11'h000, 32'h0);
		wr(14'h0004, 32'h1);
		wr(14'h0000, 32'h0);
		pd(PD_WRITE, 2'h0, 11'h0, 32'h00112233);
		pd(PD_UPDATE, 2'h0, 11'h0, 32'h0);
		tx();
		repeat (600) @(posedge clk_i);
		pd(PD_WRITE, 2'h0, 11'h0, 32'h00aabbcc);
		pd(PD_UPDATE, 2'h0, 11'h0, 32'h0);
		ck(24'h221133);
		tx();
		ck(24'hbbaacc);
		wr(14'h0008, 32'h80);
		wr(14'h0000, 32'h40);
		pd(PD_FILL, 2'h0, 11'h0, 32'h004080fe);
		pd(PD_UPDATE, 2'h0, 11'h0, 32'h0);
		tx();
		ck(24'h20407f);
		wr(14'h0000, 32'h4);
		wr(14'h000c, 32'h00ff0000);
		clr_mon();
		bus_fail_i <= 1'b1;
		ck(24'h007f00);
		bus_fail_i <= 1'b0;
		fb_state_i <= 4'h2;
		tx();
		repeat (600) @(posedge clk_i);
		chk("bits", 32'd0, {16'h0, cnt});
		fb_state_i <= 4'h8;
		tx();
		repeat (1000) @(posedge clk_i);
		field_pwr_ok_i <= 1'b0;
		repeat (5) @(posedge clk_i);
		#1 c0 = cnt;
		repeat (2000) @(posedge clk_i);
		chk("abort", {16'h0, c0}, {16'h0, cnt});
		field_pwr_ok_i <= 1'b1;
		idle();
		wr(14'h0000, 32'h2);
		clr_mon();
		repeat (12000) @(posedge clk_i);
		chk("cyclic", 32'd1, {31'h0, cnt >= 16'd24});
		wr(14'h0000, 32'h0);
		idle();
		clr_mon();
		repeat (12000) @(posedge clk_i);
		chk("cyclic", 32'd0, {16'h0, cnt});
		stop_test();
	end
endmodule // tb_pled_top
